// ===== logic/adc_clock_power_output_ctrl.sv
// Purpose: clock divider, duty cycle stabilizer control, power modes
//          and output formatting of a 12-bit pipelined converter
// Assumes: sys_clk is the input clock ahead of the divider; rst synchronous, active high
// Notes:   register port is the parallel side of the serial port
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// sample fifo
module sample_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  // ============================================================
  // storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
  // ============================================================
  // pointers and level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // registered ready: one slot kept honest against a same-cycle push
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_ready <= 1'b1;
    end else begin
      in_ready <= (count_r + (AW+1)'(push) - (AW+1)'(pop))
                  < (AW+1)'(DEPTH);
    end
  end
endmodule : sample_fifo

// ============================================================
// converter control top
module adc_clock_power_output_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int         DATA_W    = 12,
  parameter int         LATENCY   = PIPE_LATENCY,
  parameter logic [2:0] DIV_RESET = 3'h0
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // register port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata_r,
  // clock status from the analog side
  input  wire logic              clk_rate_low,
  input  wire logic              clk_freq_change,
  // samples from the converter core
  input  wire logic              sample_valid,
  output logic                   sample_ready,
  input  wire logic [DATA_W-1:0] sample_code,
  input  wire logic              over_pos,
  input  wire logic              over_neg,
  // internal clock and power controls
  output logic                   int_clk_r,
  output logic                   dcs_active_r,
  output logic                   core_on_r,
  output logic                   ref_on_r,
  // output pins
  output logic      [DATA_W-1:0] data_out_r,
  output logic                   overrange_r,
  output logic                   data_oe_r,
  output logic                   data_clock_out_r,
  output logic                   data_clock_oe_r
);
  localparam logic DCS_RST = (DIV_RESET != 3'h0);
  localparam int   STAGES  = LATENCY - 1;
  localparam int   FW      = DATA_W + 1;
  // ============================================================
  // declarations
  logic [7:0]             power_mode_r;
  logic [7:0]             output_mode_r;
  logic                   dcs_en_r;
  logic [DIV_W-1:0]       div_sel_r;
  logic [DIV_W-1:0]       div_cnt_r;
  logic                   tick;
  logic [LOCK_CNT_W-1:0]  lock_cnt_r;
  logic                   locked;
  logic                   relock;
  power_mode_t            pmode;
  out_format_t            fmt;
  logic                   powered_down;
  logic                   running;
  logic [FW-1:0]          fifo_in;
  logic [FW-1:0]          fifo_out;
  logic                   fifo_valid;
  logic                   fifo_pop;
  logic [FW-1:0]          stage_r [STAGES];
  logic [DATA_W-1:0]      fmt_word;
  logic [4:0]             half_ratio;
  logic [4:0]             phase2;
  assign pmode        = power_mode_t'(power_mode_r[PWR_MODE_LSB +: 2]);
  assign fmt          = out_format_t'(output_mode_r[FMT_LSB +: 2]);
  assign powered_down = (pmode == PWR_DOWN);
  assign running      = (pmode == PWR_NORMAL) || (pmode == PWR_RSVD);
  assign tick         = (div_cnt_r == '0);
  assign fifo_pop     = tick && running;
  // ============================================================
  // register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_mode_r  <= POWER_MODE_RST;
      output_mode_r <= OUTPUT_MODE_RST;
      dcs_en_r      <= DCS_RST;
      div_sel_r     <= DIV_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_POWER_MODE:  power_mode_r  <= reg_wdata;
        ADDR_OUTPUT_MODE: output_mode_r <= reg_wdata;
        ADDR_DCS_CTRL:    dcs_en_r      <= reg_wdata[DCS_EN_BIT];
        ADDR_CLK_DIVIDE:  div_sel_r     <= reg_wdata[DIV_W-1:0];
        default: ;
      endcase
    end
  end
  // ============================================================
  // register reads; unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_r <= READ_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_POWER_MODE:  reg_rdata_r <= power_mode_r;
        ADDR_OUTPUT_MODE: reg_rdata_r <= output_mode_r;
        ADDR_DCS_CTRL:    reg_rdata_r <= {7'h00, dcs_en_r};
        ADDR_CLK_DIVIDE:  reg_rdata_r <= {5'h00, div_sel_r};
        ADDR_CLK_STATUS: begin
          reg_rdata_r                  <= READ_ZERO;
          reg_rdata_r[STAT_LOCK_BIT]   <= locked;
          reg_rdata_r[STAT_BYPASS_BIT] <= dcs_en_r && !locked;
          reg_rdata_r[STAT_RATE_BIT]   <= clk_rate_low;
        end
        default:          reg_rdata_r <= READ_ZERO;
      endcase
    end
  end
  // ============================================================
  // input clock divider
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt_r <= '0;
    end else if (reg_wr && reg_addr == ADDR_CLK_DIVIDE) begin
      div_cnt_r <= '0;
    end else if (div_cnt_r >= div_sel_r) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end
  // ============================================================
  // stabilizer lock tracking
  // no edge of the stabilizer can be trusted while the rate is too low,
  // so the lock timer is held in reload for the whole of that time
  assign relock = clk_freq_change || clk_rate_low
               || !dcs_en_r || powered_down
               || (reg_wr && reg_addr == ADDR_CLK_DIVIDE);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lock_cnt_r <= LOCK_CNT_W'(DCS_LOCK_CYC);
    end else if (relock) begin
      lock_cnt_r <= LOCK_CNT_W'(DCS_LOCK_CYC);
    end else if (lock_cnt_r != '0) begin
      lock_cnt_r <= lock_cnt_r - 1'b1;
    end
  end
  // lock comes at the late end of the settle window
  assign locked = dcs_en_r && !clk_rate_low && (lock_cnt_r == '0);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dcs_active_r <= 1'b0;
    end else begin
      dcs_active_r <= locked;
    end
  end

  // ============================================================
  // internal clock shaping
  // rising edge always at phase zero; only the falling edge moves
  assign half_ratio = 5'(div_sel_r) + 5'h01;
  assign phase2     = {1'b0, div_cnt_r, 1'b0};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      int_clk_r <= 1'b0;
    end else if (powered_down) begin
      int_clk_r <= 1'b0;
    end else if (locked) begin
      int_clk_r <= (phase2 < half_ratio);
    end else begin
      int_clk_r <= tick;
    end
  end
  // ============================================================
  // power domains
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_on_r <= 1'b1;
      ref_on_r  <= 1'b1;
    end else begin
      core_on_r <= running;
      ref_on_r  <= !powered_down;
    end
  end
  // ============================================================
  // sample capture; clamping codes and flag travel together
  always_comb begin
    fifo_in = {1'b0, sample_code};
    if (over_pos) begin
      fifo_in = {1'b1, {DATA_W{1'b1}}};
    end else if (over_neg) begin
      fifo_in = {1'b1, {DATA_W{1'b0}}};
    end
  end
  // core stalls through sample_ready while the pipeline is frozen
  sample_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (sample_valid && tick),
    .in_ready  (sample_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );
  // ============================================================
  // latency pipeline, one stage per sample clock
  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi++) begin : g_pipe
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          stage_r[gi] <= '0;
        end else if (fifo_pop) begin
          if (gi == 0) begin
            stage_r[gi] <= fifo_valid ? fifo_out : '0;
          end else begin
            stage_r[gi] <= stage_r[(gi > 0) ? gi - 1 : 0];
          end
        end
      end
    end
  endgenerate
  // ============================================================
  // output format
  always_comb begin
    fmt_word = stage_r[STAGES-1][DATA_W-1:0];
    unique case (fmt)
      FMT_TWOS: begin
        fmt_word[DATA_W-1] = ~stage_r[STAGES-1][DATA_W-1];
      end
      FMT_GRAY: begin
        fmt_word = stage_r[STAGES-1][DATA_W-1:0]
                 ^ (stage_r[STAGES-1][DATA_W-1:0] >> 1);
      end
      default: ;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_out_r  <= '0;
      overrange_r <= 1'b0;
    end else if (fifo_pop) begin
      data_out_r  <= fmt_word;
      overrange_r <= stage_r[STAGES-1][DATA_W];
    end
  end

  // ============================================================
  // data clock: rises mid-word at ratios above one so capture sees settled data; held low at ratio one
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_clock_out_r <= 1'b0;
    end else if (!running) begin
      data_clock_out_r <= 1'b0;
    end else begin
      data_clock_out_r <= (div_sel_r == '0) ? 1'b0
                        : !(phase2 < half_ratio);
    end
  end

  // ============================================================
  // output enables; bit four is a static setting, not a bus grant
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_oe_r       <= 1'b1;
      data_clock_oe_r <= 1'b1;
    end else begin
      data_oe_r       <= !powered_down
                      && !output_mode_r[THREE_STATE_BIT];
      data_clock_oe_r <= !powered_down;
    end
  end

endmodule : adc_clock_power_output_ctrl

`default_nettype wire

// ===== common/adc_ctrl_pkg.sv
// Purpose: shared constants of the converter control block
// Assumes: 8-bit register port, 12-bit sample words
// Notes:   offsets are byte addresses of the register port
package adc_ctrl_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_POWER_MODE  = 8'h08;
  localparam logic [7:0] ADDR_DCS_CTRL    = 8'h09;
  localparam logic [7:0] ADDR_CLK_DIVIDE  = 8'h0B;
  localparam logic [7:0] ADDR_CLK_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_OUTPUT_MODE = 8'h14;

  // ==========================================================
  // field positions and reset values
  localparam int         PWR_MODE_LSB     = 0;
  localparam int         DCS_EN_BIT       = 0;
  localparam int         FMT_LSB          = 0;
  localparam int         THREE_STATE_BIT  = 4;
  localparam int         STAT_LOCK_BIT    = 0;
  localparam int         STAT_BYPASS_BIT  = 1;
  localparam int         STAT_RATE_BIT    = 2;
  localparam logic [7:0] POWER_MODE_RST   = 8'h00;
  localparam logic [7:0] OUTPUT_MODE_RST  = 8'h01;
  localparam logic [7:0] READ_ZERO        = 8'h00;

  // ==========================================================
  // modes
  typedef enum logic [1:0] {
    PWR_NORMAL  = 2'b00,
    PWR_DOWN    = 2'b01,
    PWR_STANDBY = 2'b10,
    PWR_RSVD    = 2'b11
  } power_mode_t;

  typedef enum logic [1:0] {
    FMT_OFFSET  = 2'b00,
    FMT_TWOS    = 2'b01,
    FMT_GRAY    = 2'b10,
    FMT_RSVD    = 2'b11
  } out_format_t;

  // ==========================================================
  // divider, latency and timing
  localparam int DIV_MAX          = 8;
  localparam int DIV_W            = 3;
  localparam int PIPE_LATENCY     = 10;
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int DCS_MIN_RATE_MHZ = 40;
  localparam int DCS_LOCK_NS      = 1500;
  localparam int DCS_LOCK_CYC     =
    (DCS_LOCK_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int LOCK_CNT_W       = 6;
  localparam int FIFO_DEPTH       = 4;

endpackage : adc_ctrl_pkg

// ===== sim/adc_ctrl_props_properties.sv
// Purpose: port checks of the converter control block
// Assumes: divide ratio tracked from register writes
// Notes:   overrange latency checked at ratio one only
`timescale 1ns/1ps
`default_nettype none
// ====================
// checker
module adc_ctrl_props
  import adc_ctrl_pkg::*;
#(
  parameter logic [2:0] DIV_RESET = 3'h0
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_r,
  // status and samples
  input wire logic       clk_rate_low,
  input wire logic       clk_freq_change,
  input wire logic       sample_valid,
  input wire logic       sample_ready,
  input wire logic       over_pos,
  input wire logic       over_neg,
  // outputs
  input wire logic       int_clk_r,
  input wire logic       dcs_active_r,
  input wire logic       core_on_r,
  input wire logic       ref_on_r,
  input wire logic       overrange_r,
  input wire logic       data_oe_r,
  input wire logic       data_clock_oe_r
);
  logic [2:0] div_r;
  logic [6:0] since_r;
  logic       take;
  logic       div_wr;
  assign div_wr = reg_wr && reg_addr == ADDR_CLK_DIVIDE;
  assign take = sample_valid && sample_ready && core_on_r && div_r == 3'h0;
  always_ff @(posedge sys_clk) begin
    if (rst) div_r <= DIV_RESET;
    else if (div_wr) div_r <= reg_wdata[2:0];
  end
  // saturates high in reset: no claim on the first lock
  always_ff @(posedge sys_clk) begin
    if (rst) since_r <= 7'h7F;
    else if (clk_freq_change || clk_rate_low || div_wr) since_r <= 7'h00;
    else if (since_r != 7'h7F) since_r <= since_r + 7'h01;
  end
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_pd_hiz: assert property (
    reg_wr && reg_addr == ADDR_POWER_MODE && reg_wdata[1:0] == 2'b01
    |-> ##2 !data_oe_r && !data_clock_oe_r && !ref_on_r)
    else $error("outputs driven in power-down");
  a_oeb_hiz: assert property (
    reg_wr && reg_addr == ADDR_OUTPUT_MODE && reg_wdata[4] |-> ##2 !data_oe_r)
    else $error("data pins not released");
  a_unmapped_zero: assert property (
    reg_rd && !(reg_addr inside {8'h08, 8'h09, 8'h0B, 8'h0C, 8'h14})
    |=> reg_rdata_r == READ_ZERO)
    else $error("unmapped read not zero");
  a_bypass_low: assert property (
    clk_rate_low |=> !dcs_active_r)
    else $error("stabilizer active at low rate");
  a_relock_wait: assert property (
    $rose(dcs_active_r) |-> since_r >= 7'h26)
    else $error("lock came too early");
  a_locked_duty: assert property (
    dcs_active_r && $past(dcs_active_r) && div_r == 3'h1
    |-> int_clk_r != $past(int_clk_r))
    else $error("locked clock not half duty");
  a_ovr_set: assert property (
    take && (over_pos || over_neg) |-> ##11 overrange_r)
    else $error("overrange flag missing");
  a_ovr_clear: assert property (
    take && !over_pos && !over_neg |-> ##11 !overrange_r)
    else $error("overrange flag spurious");
endmodule : adc_ctrl_props

bind adc_clock_power_output_ctrl adc_ctrl_props #(.DIV_RESET(DIV_RESET))
  u_adc_ctrl_props (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata_r, .clk_rate_low, .clk_freq_change, .sample_valid,
  .sample_ready, .over_pos, .over_neg, .int_clk_r, .dcs_active_r,
  .core_on_r, .ref_on_r, .overrange_r, .data_oe_r, .data_clock_oe_r);
`default_nettype wire

// ===== sim/capture_model.sv
// Purpose: capture register on the far side of the data pins
// Assumes: ratio one, every edge carries a word
// Notes:   a released bus reads as the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
// ====================
// capture model
module capture_model (
  // clock
  input  wire logic        sys_clk,
  // pins
  input  wire logic        data_oe_r,
  input  wire logic [11:0] data_out_r,
  input  wire logic        overrange_r,
  // captured word
  output logic      [11:0] cap_data,
  output logic             cap_or
);
  logic [12:0] pin;
  assign pin = data_oe_r ? {overrange_r, data_out_r} : ~{cap_or, cap_data};
  always_ff @(posedge sys_clk) begin
    {cap_or, cap_data} <= pin;
  end
endmodule : capture_model
`default_nettype wire

// ===== sim/adc_clock_power_output_ctrl_test.sv
// Purpose: self-checking bench of the converter control block
// Assumes: capture model stands on the data pins
// Notes:   words checked at ratio one, twelve edges after the take
`timescale 1ns/1ps
`default_nettype none
module adc_clock_power_output_ctrl_test;
  import adc_ctrl_pkg::*;
  // ====================
  // signals
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata_r;
  logic        clk_rate_low = 1'b0;
  logic        clk_freq_change = 1'b0;
  logic        sample_valid = 1'b0;
  logic        sample_ready;
  logic [11:0] sample_code = 12'h000;
  logic        over_pos = 1'b0;
  logic        over_neg = 1'b0;
  logic        int_clk_r, dcs_active_r, core_on_r, ref_on_r;
  logic [11:0] data_out_r, cap_data;
  logic        overrange_r, data_oe_r, cap_or;
  logic        data_clock_out_r, data_clock_oe_r;
  logic [12:0] exp_q[$];
  logic [11:0] tk_sr = 12'h000;
  logic [31:0] seed = 32'h0000593C;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n, m, d, k;

  always #20 sys_clk = ~sys_clk;
  adc_clock_power_output_ctrl #(.DIV_RESET(3'h1))
    u_adc_clock_power_output_ctrl (.sys_clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata_r, .clk_rate_low, .clk_freq_change,
    .sample_valid, .sample_ready, .sample_code, .over_pos, .over_neg,
    .int_clk_r, .dcs_active_r, .core_on_r, .ref_on_r, .data_out_r,
    .overrange_r, .data_oe_r, .data_clock_out_r, .data_clock_oe_r);
  capture_model u_capture_model (.sys_clk, .data_oe_r, .data_out_r,
    .overrange_r, .cap_data, .cap_or);

  // ====================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic [11:0] fmt(input logic [11:0] ob, logic [1:0] f);
    case (f)
      2'b01: return ob ^ 12'h800;
      2'b10: return ob ^ (ob >> 1);
      default: return ob;
    endcase
  endfunction : fmt
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [12:0] seen, e);
    checks_done++;
    if (seen !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, v);
    @(posedge sys_clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, mask, e);
    logic [7:0] v;
    @(posedge sys_clk) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge sys_clk) #1;
    reg_rd = 1'b0;
    v = reg_rdata_r & mask;
    chk("rdata", 13'(v), 13'(e));
  endtask : rc
  task automatic idle(input int c);
    sample_valid = 1'b0;
    repeat (c) @(posedge sys_clk) #1;
  endtask : idle
  task automatic lock_wait;
    n = 0;
    while (!dcs_active_r && n < 128) begin
      @(posedge sys_clk) #1;
      n++;
    end
    chk("lock", 13'(dcs_active_r), 13'h1);
  endtask : lock_wait
  // driver notes the word before offering it
  task automatic send(input logic [11:0] c, input logic p, g, logic [1:0] f);
    exp_q.push_back({p | g, fmt(p ? 12'hFFF : (g ? 12'h000 : c), f)});
    sample_code = c;
    over_pos = p;
    over_neg = g;
    sample_valid = 1'b1;
    n = 0;
    while (!sample_ready && n < 20) begin
      @(posedge sys_clk) #1;
      n++;
    end
    @(posedge sys_clk) #1;
  endtask : send

  // ====================
  // watcher and timeout
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    tk_sr <= {tk_sr[10:0], sample_valid & sample_ready & core_on_r & !rst};
    if (tk_sr[11]) chk("word", {cap_or, cap_data}, exp_q.pop_front());
    if (cyc == 5000) begin
      err_count++;
      final_report();
    end
  end

  // ====================
  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 rst = 1'b0;
    rc(ADDR_OUTPUT_MODE, 8'hFF, OUTPUT_MODE_RST);
    rc(ADDR_POWER_MODE, 8'hFF, POWER_MODE_RST);
    rc(ADDR_DCS_CTRL, 8'h01, 8'h01);
    wr(8'h13, 8'h5A);
    rc(8'h13, 8'hFF, READ_ZERO);
    lock_wait();
    clk_rate_low = 1'b1;
    repeat (3) @(posedge sys_clk) #1;
    chk("dcs", 13'(dcs_active_r), 13'h0);
    rc(ADDR_CLK_STATUS, 8'h07, 8'h06);
    clk_rate_low = 1'b0;
    clk_freq_change = 1'b1;
    @(posedge sys_clk) #1;
    clk_freq_change = 1'b0;
    lock_wait();
    // ratio eight, still unlocked: raw pulses
    wr(ADDR_CLK_DIVIDE, 8'h07);
    m = 0;
    d = 0;
    repeat (32) begin
      @(posedge sys_clk) #1;
      m += int_clk_r;
      d += data_clock_out_r;
    end
    chk("int_clk", 13'(m), 13'h4);
    chk("dclk", 13'(d), 13'h10);
    wr(ADDR_CLK_DIVIDE, 8'h00);
    for (k = 0; k < 4; k++) begin
      wr(ADDR_OUTPUT_MODE, 8'(k));
      send(12'h800, 1'b0, 1'b0, 2'(k));
      send(12'hFFF, 1'b0, 1'b0, 2'(k));
      send(12'h000, 1'b1, 1'b0, 2'(k));
      send(12'hFFF, 1'b0, 1'b1, 2'(k));
      repeat (8) begin
        seed = xs(seed);
        send(seed[11:0], 1'b0, 1'b0, 2'(k));
      end
      idle(14);
    end
    // standby freezes the pipe; fifo fills and refuses
    wr(ADDR_POWER_MODE, 8'h02);
    idle(3);
    chk("pwr", {core_on_r, ref_on_r, data_oe_r}, 13'h3);
    sample_code = 12'h321;
    sample_valid = 1'b1;
    n = 0;
    repeat (12) begin
      n += sample_ready;
      @(posedge sys_clk) #1;
    end
    chk("full", {sample_ready, 1'(n >= FIFO_DEPTH)}, 13'h1);
    idle(1);
    wr(ADDR_POWER_MODE, 8'h00);
    idle(10);
    chk("drain", {sample_ready, data_out_r}, 13'h1321);
    wr(ADDR_POWER_MODE, 8'h01);
    idle(2);
    chk("pd", {data_oe_r, data_clock_oe_r, ref_on_r, core_on_r}, 13'h0);
    wr(ADDR_POWER_MODE, 8'h00);
    wr(ADDR_OUTPUT_MODE, 8'h11);
    idle(2);
    chk("oe", 13'(data_oe_r), 13'h0);
    rc(ADDR_OUTPUT_MODE, 8'hFF, 8'h11);
    chk("queue", 13'(exp_q.size()), 13'h0);
    final_report();
  end
endmodule : adc_clock_power_output_ctrl_test
`default_nettype wire
